// ==== aluct_timer.sv ====
// Purpose: per-instruction clock, read and write cycle counts and pacing
// Assumes: request inputs come from logic on clk; no wait states unless stalled
// Notes:   busy stands exactly the computed clock count when never stalled
//
// Operation
// - flagged entries add the address-calculation clocks, reads and writes given.
// - counts cover execution, write-back and next instruction word fetch.
// - two-operand into data reg 4/6; add/sub into address reg 8/6; one read.
// - register-to-memory forms take 8 (1/1) or long 12 (1/2).
// - compare into address reg 6 clocks one read; no memory form.
// - signed divide 122, unsigned 108, multiply 42 or register form 40.
// - xor into data reg needs data reg source; 4/6 with no address cost.
// - address register destinations refuse byte size.
// - loop byte/word add into data reg 16, 22 or 20 clocks.
// - loop operand only indirect forms; predecrement adds two clocks.
// - loop long add into data reg 22 (2 reads), 28 (4), 26.
// - immediates 8 (2/0), long 14 (3/0); memory 12 and 20 plus address.
// - immediate compare 8 or 12 clocks, never a write.
// - quick add/sub 4 or long 8; address reg word 4; quick move 4.
// - register single-operand 4/6; decimal negate 6; set/test 4; test-set 4 or 14.
// - single-operand memory forms 8 (1/1), long 12 (1/2), plus address; test 4 (1/0), test-set 14 (2/1).
`timescale 1ns/1ns
module aluct_timer
    import aluct_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // request
    input  wire logic                  start,
    input  wire aluct_pkg::aluct_op_t   op,
    input  wire aluct_pkg::aluct_size_t size,
    input  wire aluct_pkg::aluct_form_t form,
    input  wire logic                  src_dreg,
    input  wire logic                  src_reg,
    // loop mode
    input  wire logic                  loop_mode,
    input  wire aluct_pkg::aluct_loop_t loop_case,
    input  wire logic                  ea_indirect,
    input  wire logic                  ea_predec,
    // address calculation cost
    input  wire logic [7:0]            ea_clocks,
    input  wire logic [3:0]            ea_reads,
    input  wire logic [3:0]            ea_writes,
    // bus wait stall
    input  wire logic                  bus_wait,
    // result
    output logic                       busy,
    output logic                       done,
    output logic                       illegal,
    output logic [7:0]                 clocks_total,
    output logic [3:0]                 reads_total,
    output logic [3:0]                 writes_total
);
    import aluct_pkg::*;

    aluct_state_t     state;
    logic [CW-1:0]    remain;
    logic [CW-1:0]    next_clk;
    logic [BW-1:0]    next_rd;
    logic [BW-1:0]    next_wr;
    logic             next_ok;
    logic             next_ea;
    logic             is_long;
    logic [CW-1:0]    sum_clk;
    logic [BW-1:0]    sum_rd;
    logic [BW-1:0]    sum_wr;

    assign is_long = (size == SZ_LONG);

    ////////////////////////////////////////////////////////////////////
    // lookup of base figures for the request
    always_comb begin
        next_clk = C4;
        next_rd  = N1;
        next_wr  = N0;
        next_ok  = 1'b1;
        next_ea  = 1'b0;
        if (size == 2'h3) begin
            next_ok = 1'b0;
        end
        if (loop_mode) begin
            // loop forms of the two-operand group only
            next_ok = next_ok && ea_indirect;
            next_rd = is_long ? ((loop_case == LP_CONT) ? N2 : N4)
                              : ((loop_case == LP_CONT) ? N1 : N3);
            next_wr = (form == FM_MEM) ? (is_long ? N2 : N1) : N0;
            unique case (op)
                OP_CMP: begin
                    next_ok = next_ok && (form != FM_MEM) && (form != FM_AREG || size != SZ_BYTE);
                    unique case (loop_case)
                        LP_CONT: next_clk = is_long ? L_CMP_L_CONT : L_CMP_BW_CONT;
                        LP_TRUE: next_clk = is_long ? L_CMP_L_TRUE : L_CMP_BW_TRUE;
                        default: next_clk = is_long ? L_CMP_L_EXP : L_CMP_BW_EXP;
                    endcase
                end
                OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
                    unique case (loop_case)
                        LP_CONT: next_clk = is_long ? L_L_CONT : L_BW_CONT;
                        LP_TRUE: next_clk = is_long ? L_L_TRUE : L_BW_TRUE;
                        default: next_clk = is_long ? L_L_EXP : L_BW_EXP;
                    endcase
                    if (form == FM_AREG) begin
                        next_ok = next_ok && (op == OP_ADD || op == OP_SUB) && !(size == SZ_BYTE);
                        if (!is_long) next_clk = next_clk + L_AREG_ADJ;
                    end else if (form == FM_MEM) begin
                        if (is_long) next_clk = next_clk + L_MEM_ADJ;
                    end else begin
                        next_ok = next_ok && (op != OP_XOR);
                        if (op == OP_SUB && is_long) next_clk = next_clk - L_SUBL_ADJ;
                    end
                end
                default: next_ok = 1'b0;
            endcase
            if (ea_predec) next_clk = next_clk + L_PREDEC;
            if (loop_case == 2'h3) next_ok = 1'b0;
        end else begin
            unique case (op)
                OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_XOR: begin
                    next_ea = !(op == OP_XOR && form == FM_DREG);
                    if (form == FM_DREG) begin
                        next_clk = is_long ? C6 : C4;
                        next_ok  = next_ok && (op != OP_XOR || src_dreg);
                    end else if (form == FM_AREG) begin
                        next_ok  = next_ok && size != SZ_BYTE;
                        next_ok  = next_ok && (op == OP_ADD || op == OP_SUB || op == OP_CMP);
                        next_clk = (op == OP_CMP || is_long) ? C6 : C8;
                    end else begin
                        next_ok  = next_ok && (op != OP_CMP);
                        next_clk = is_long ? C12 : C8;
                        next_wr  = is_long ? N2 : N1;
                    end
                end
                OP_SDIV, OP_UDIV, OP_MUL: begin
                    next_ok  = next_ok && (form == FM_DREG);
                    next_ea  = !(op == OP_MUL && src_reg);
                    next_clk = (op == OP_SDIV) ? C_SDIV : (op == OP_UDIV) ? C_UDIV
                             : (src_reg ? C_MULR : C_MULE);
                end
                OP_ADD_IMMEDIATE, OP_SUBTRACT_IMMEDIATE, OP_AND_IMMEDIATE, OP_ORI, OP_XORI, OP_COMPARE_IMMEDIATE: begin
                    next_ok = next_ok && (form != FM_AREG);
                    next_rd = is_long ? N3 : N2;
                    if (form == FM_MEM) begin
                        next_ea  = 1'b1;
                        next_clk = is_long ? C20 : C12;
                        next_wr  = (op == OP_COMPARE_IMMEDIATE) ? N0 : (is_long ? N2 : N1);
                        if (op == OP_COMPARE_IMMEDIATE) next_clk = is_long ? C12 : C8;
                    end else begin
                        next_clk = is_long ? ((op == OP_COMPARE_IMMEDIATE) ? C12 : C14) : C8;
                    end
                end
                OP_QADD, OP_QSUB: begin
                    if (form == FM_MEM) begin
                        next_ea  = 1'b1;
                        next_clk = is_long ? C12 : C8;
                        next_wr  = is_long ? N2 : N1;
                    end else begin
                        next_ok  = next_ok && !(form == FM_AREG && size == SZ_BYTE);
                        next_clk = is_long ? C8 : C4;
                    end
                end
                OP_QMOVE: begin
                    next_ok  = next_ok && form == FM_DREG && is_long;
                    next_clk = C4;
                end
                OP_NEG, OP_NEGATE_WITH_EXTEND, OP_NOT, OP_DNEG, OP_SETCC, OP_TSET, OP_TST: begin
                    next_ok = next_ok && (form != FM_AREG);
                    if (op == OP_DNEG || op == OP_SETCC || op == OP_TSET) begin
                        next_ok = next_ok && size == SZ_BYTE;
                    end
                    if (form == FM_MEM) begin
                        next_ea  = 1'b1;
                        next_clk = is_long ? C12 : C8;
                        next_wr  = is_long ? N2 : N1;
                        if (op == OP_TSET) begin
                            next_clk = C14;
                            next_rd  = N2;
                            next_wr  = N1;
                        end else if (op == OP_TST) begin
                            next_clk = C4;
                            next_wr  = N0;
                        end
                    end else begin
                        next_clk = (op == OP_DNEG) ? C6 : (is_long && op != OP_TST) ? C6 : C4;
                    end
                end
                default: next_ok = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // totals including address calculation where flagged
    always_comb begin
        sum_clk = next_clk;
        sum_rd  = next_rd;
        sum_wr  = next_wr;
        if (next_ea && !loop_mode) begin
            sum_clk = next_clk + ea_clocks;
            sum_rd  = next_rd + ea_reads;
            sum_wr  = next_wr + ea_writes;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer: busy for the counted clocks, stalled by bus_wait
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state  <= ST_IDLE;
            remain <= 8'h00;
            busy   <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start && next_ok && sum_clk != 8'h00) begin
                        state  <= ST_RUN;
                        remain <= sum_clk;
                        busy   <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!bus_wait) begin
                        remain <= remain - 8'h01;
                        if (remain == 8'h01) begin
                            state <= ST_IDLE;
                            busy  <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion pulse and refusal flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done    <= 1'b0;
            illegal <= 1'b0;
        end else begin
            done    <= 1'b0;
            illegal <= 1'b0;
            if (state == ST_RUN && !bus_wait && remain == 8'h01) begin
                done <= 1'b1;
            end else if (state == ST_IDLE && start && !(next_ok && sum_clk != 8'h00)) begin
                done    <= 1'b1;
                illegal <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // captured figures of the accepted request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clocks_total <= 8'h00;
            reads_total  <= 4'h0;
            writes_total <= 4'h0;
        end else if (state == ST_IDLE && start) begin
            clocks_total <= next_ok ? sum_clk : 8'h00;
            reads_total  <= next_ok ? sum_rd : 4'h0;
            writes_total <= next_ok ? sum_wr : 4'h0;
        end
    end
endmodule

// ==== aluct_pkg.sv ====
// Purpose: shared codes and cycle figures for the instruction timing block
// Assumes: counts are processor clock periods with zero-wait bus cycles
// Notes:   operation, form, size and loop-outcome codes used on the ports
package aluct_pkg;
    // operation codes
    typedef enum logic [4:0] {
        OP_ADD=5'h00, OP_SUB=5'h01, OP_AND=5'h02, OP_OR=5'h03, OP_CMP=5'h04,
        OP_XOR=5'h05, OP_SDIV=5'h06, OP_UDIV=5'h07, OP_MUL=5'h08,
        OP_ADD_IMMEDIATE=5'h09, OP_SUBTRACT_IMMEDIATE=5'h0a, OP_AND_IMMEDIATE=5'h0b, OP_ORI=5'h0c,
        OP_XORI=5'h0d, OP_COMPARE_IMMEDIATE=5'h0e, OP_QADD=5'h0f, OP_QSUB=5'h10,
        OP_QMOVE=5'h11, OP_NEG=5'h12, OP_NEGATE_WITH_EXTEND=5'h13, OP_NOT=5'h14,
        OP_DNEG=5'h15, OP_SETCC=5'h16, OP_TSET=5'h17, OP_TST=5'h18
    } aluct_op_t;
    // destination form
    typedef enum logic [1:0] {
        FM_DREG=2'h0, FM_AREG=2'h1, FM_MEM=2'h2
    } aluct_form_t;
    // operand size
    typedef enum logic [1:0] {
        SZ_BYTE=2'h0, SZ_WORD=2'h1, SZ_LONG=2'h2
    } aluct_size_t;
    // loop-mode outcome
    typedef enum logic [1:0] {
        LP_CONT=2'h0, LP_TRUE=2'h1, LP_EXP=2'h2
    } aluct_loop_t;
    // fsm states
    typedef enum logic [1:0] {
        ST_IDLE=2'b01, ST_RUN=2'b10
    } aluct_state_t;
    // widths
    localparam int CW = 8;
    localparam int BW = 4;
    // clock figures
    localparam logic [7:0] C4   = 8'h04;
    localparam logic [7:0] C6   = 8'h06;
    localparam logic [7:0] C8   = 8'h08;
    localparam logic [7:0] C12  = 8'h0c;
    localparam logic [7:0] C14  = 8'h0e;
    localparam logic [7:0] C20  = 8'h14;
    localparam logic [7:0] C_SDIV = 8'h7a; // 122
    localparam logic [7:0] C_UDIV = 8'h6c; // 108
    localparam logic [7:0] C_MULE = 8'h2a; // 42, worst case
    localparam logic [7:0] C_MULR = 8'h28; // 40
    // loop-mode figures: continue, cc true, expired
    localparam logic [7:0] L_BW_CONT = 8'h10; // 16
    localparam logic [7:0] L_BW_TRUE = 8'h16; // 22
    localparam logic [7:0] L_BW_EXP  = 8'h14; // 20
    localparam logic [7:0] L_L_CONT  = 8'h16; // 22
    localparam logic [7:0] L_L_TRUE  = 8'h1c; // 28
    localparam logic [7:0] L_L_EXP   = 8'h1a; // 26
    localparam logic [7:0] L_CMP_BW_CONT = 8'h0c; // 12
    localparam logic [7:0] L_CMP_BW_TRUE = 8'h12; // 18
    localparam logic [7:0] L_CMP_BW_EXP  = 8'h10; // 16
    localparam logic [7:0] L_CMP_L_CONT  = 8'h12; // 18
    localparam logic [7:0] L_CMP_L_TRUE  = 8'h18; // 24
    localparam logic [7:0] L_CMP_L_EXP   = 8'h14; // 20
    localparam logic [7:0] L_AREG_ADJ = 8'h02; // address reg bw extra
    localparam logic [7:0] L_MEM_ADJ  = 8'h02; // memory long extra
    localparam logic [7:0] L_SUBL_ADJ = 8'h02; // sub long into data reg less
    localparam logic [7:0] L_PREDEC   = 8'h02;
    // bus cycle figures
    localparam logic [3:0] N0 = 4'h0;
    localparam logic [3:0] N1 = 4'h1;
    localparam logic [3:0] N2 = 4'h2;
    localparam logic [3:0] N3 = 4'h3;
    localparam logic [3:0] N4 = 4'h4;
endpackage

// ==== aluct_timer_assertions.sv ====
// Purpose: port-level checks of the instruction timing block
// Assumes: one clock domain, resetn active low, zero-wait unless bus_wait
// Notes:   bound to every aluct_timer instance
`timescale 1ns/1ns
module aluct_timer_chk
    import aluct_pkg::*;
(
    // clock and reset
    input wire logic                   clk,
    input wire logic                   resetn,
    // request
    input wire logic                   start,
    input wire aluct_pkg::aluct_op_t   op,
    input wire aluct_pkg::aluct_size_t size,
    input wire aluct_pkg::aluct_form_t form,
    input wire logic                   src_dreg,
    input wire logic                   src_reg,
    input wire logic                   loop_mode,
    input wire aluct_pkg::aluct_loop_t loop_case,
    input wire logic                   ea_indirect,
    input wire logic                   ea_predec,
    input wire logic [7:0]             ea_clocks,
    input wire logic [3:0]             ea_reads,
    input wire logic [3:0]             ea_writes,
    input wire logic                   bus_wait,
    // result
    input wire logic                   busy,
    input wire logic                   done,
    input wire logic                   illegal,
    input wire logic [7:0]             clocks_total,
    input wire logic [3:0]             reads_total,
    input wire logic [3:0]             writes_total
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic       tk;
    logic [7:0] bcnt;
    logic [7:0] wcnt;
    // a request is taken only while idle
    assign tk = start && !busy;
    // busy and stalled cycles of the request in flight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bcnt <= 8'h00;
            wcnt <= 8'h00;
        end else begin
            bcnt <= tk ? 8'h00 : bcnt + {7'h00, busy};
            wcnt <= tk ? 8'h00 : wcnt + {7'h00, busy & bus_wait};
        end
    end
    sequence s_neg_take;
        tk && op == OP_NEG && form == FM_DREG && size == SZ_WORD && !loop_mode;
    endsequence
    sequence s_run4;
        busy [*4] ##1 (done && !busy);
    endsequence
    property p_byte_areg;
        tk && form == FM_AREG && size == SZ_BYTE |=> done && illegal && !busy;
    endproperty
    a_byte_areg: assert property (p_byte_areg) else $error("byte into address reg accepted");
    property p_cmp_mem;
        tk && op == OP_CMP && form == FM_MEM |=> illegal;
    endproperty
    a_cmp_mem: assert property (p_cmp_mem) else $error("compare to memory accepted");
    property p_xor_src;
        tk && op == OP_XOR && form == FM_DREG && !src_dreg && !loop_mode |=> illegal;
    endproperty
    a_xor_src: assert property (p_xor_src) else $error("xor without data reg source accepted");
    property p_refuse_zero;
        illegal |-> done && !busy && clocks_total == 8'h00 && reads_total == 4'h0;
    endproperty
    a_refuse_zero: assert property (p_refuse_zero) else $error("refusal with figures");
    property p_add_dreg;
        tk && op == OP_ADD && form == FM_DREG && size == SZ_WORD && !loop_mode
        |=> clocks_total == 8'(C4 + $past(ea_clocks)) && reads_total == 4'(N1 + $past(ea_reads));
    endproperty
    a_add_dreg: assert property (p_add_dreg) else $error("add into data reg figures wrong");
    property p_sdiv;
        tk && op == OP_SDIV && form == FM_DREG && size == SZ_WORD && !loop_mode
        |=> clocks_total == 8'(C_SDIV + $past(ea_clocks));
    endproperty
    a_sdiv: assert property (p_sdiv) else $error("signed divide clocks wrong");
    property p_compare_immediate;
        tk && op == OP_COMPARE_IMMEDIATE && ea_writes == 4'h0 |=> writes_total == 4'h0;
    endproperty
    a_compare_immediate: assert property (p_compare_immediate) else $error("immediate compare writes");
    property p_loop_add;
        tk && loop_mode && ea_indirect && op == OP_ADD && form == FM_DREG && size == SZ_WORD && loop_case == LP_CONT
        |=> clocks_total == ($past(ea_predec) ? 8'(L_BW_CONT + L_PREDEC) : L_BW_CONT);
    endproperty
    a_loop_add: assert property (p_loop_add) else $error("loop add clocks wrong");
    property p_len;
        done && !illegal && wcnt == 8'h00 |-> bcnt == clocks_total;
    endproperty
    a_len: assert property (p_len) else $error("busy length differs from count");
    property p_neg_run;
        disable iff (!resetn || bus_wait) s_neg_take |=> s_run4;
    endproperty
    a_neg_run: assert property (p_neg_run) else $error("negate run not four clocks");
endmodule
bind aluct_timer aluct_timer_chk u_chk (.clk(clk), .resetn(resetn), .start(start), .op(op), .size(size),
    .form(form), .src_dreg(src_dreg), .src_reg(src_reg), .loop_mode(loop_mode), .loop_case(loop_case),
    .ea_indirect(ea_indirect), .ea_predec(ea_predec), .ea_clocks(ea_clocks), .ea_reads(ea_reads),
    .ea_writes(ea_writes), .bus_wait(bus_wait), .busy(busy), .done(done), .illegal(illegal),
    .clocks_total(clocks_total), .reads_total(reads_total), .writes_total(writes_total));

// ==== aluct_bus_model.sv ====
// Purpose: system bus memory seen by the core, prompt or slow
// Assumes: wait decided on the clock edge
// Notes:   slow mode stretches every third cycle
`timescale 1ns/1ns
module aluct_bus_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // mode
    input wire logic slow,
    // stall to core
    output logic     bus_wait
);
    logic [1:0] phase;
    // wait states only while slow, never otherwise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 2'h0;
            bus_wait <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            bus_wait <= slow && phase == 2'h2;
        end
    end
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench of the instruction timing block
// Assumes: address cost of 4 clocks, 1 read, 0 writes; 1 write for the memory test request
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/1ns
module tb;
    import aluct_pkg::*;
    logic clk, resetn, start, src_dreg, src_reg, loop_mode, ea_indirect, ea_predec, slow;
    logic busy, done, illegal, bus_wait;
    aluct_op_t op;
    aluct_size_t size;
    aluct_form_t form;
    aluct_loop_t loop_case;
    logic [7:0] ea_clocks, clocks_total;
    logic [3:0] ea_reads, ea_writes, reads_total, writes_total;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    aluct_timer uut (.clk(clk), .resetn(resetn), .start(start), .op(op), .size(size), .form(form),
        .src_dreg(src_dreg), .src_reg(src_reg), .loop_mode(loop_mode), .loop_case(loop_case),
        .ea_indirect(ea_indirect), .ea_predec(ea_predec), .ea_clocks(ea_clocks), .ea_reads(ea_reads),
        .ea_writes(ea_writes), .bus_wait(bus_wait), .busy(busy), .done(done), .illegal(illegal),
        .clocks_total(clocks_total), .reads_total(reads_total), .writes_total(writes_total));
    aluct_bus_model u_bus (.clk(clk), .resetn(resetn), .slow(slow), .bus_wait(bus_wait));
    // clock
    always #25 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_f(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // one request, then wait for done and judge figures and busy length
    task automatic go(input aluct_op_t o, input aluct_size_t s, input aluct_form_t f,
                      input logic [7:0] xc, input logic [3:0] xr, input logic [3:0] xw, input logic xi);
        int n = 0;
        int nb = 0;
        int nw = 0;
        op = o;
        size = s;
        form = f;
        start = 1'b1;
        @(posedge clk);
        #2 start = 1'b0;
        while (done !== 1'b1 && n < 300) begin
            nb += (busy === 1'b1);
            nw += (busy === 1'b1 && bus_wait === 1'b1);
            @(posedge clk);
            #2 n++;
        end
        cmp_f(done, 1'b1);
        cmp_f(illegal, xi);
        cmp_v(clocks_total, xc);
        cmp_v({4'h0, reads_total}, {4'h0, xr});
        cmp_v({4'h0, writes_total}, {4'h0, xw});
        cmp_v(8'(nb - nw), xc);
        // a refusal answers at once: let an edge pass so start is not raised in the step that lowered it
        if (n == 0) begin
            @(posedge clk);
            #2 n++;
        end
    endtask
    task automatic t_std();
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h08, 4'h2, 4'h0, 1'b0);
        go(OP_SUB, SZ_WORD, FM_AREG, 8'h0c, 4'h2, 4'h0, 1'b0);
        go(OP_CMP, SZ_LONG, FM_AREG, 8'h0a, 4'h2, 4'h0, 1'b0);
        go(OP_XOR, SZ_LONG, FM_MEM, 8'h10, 4'h2, 4'h2, 1'b0);
        go(OP_XOR, SZ_WORD, FM_DREG, 8'h04, 4'h1, 4'h0, 1'b0);
        src_dreg = 1'b0;
        go(OP_XOR, SZ_WORD, FM_DREG, 8'h00, 4'h0, 4'h0, 1'b1);
        src_dreg = 1'b1;
        go(OP_ADD, SZ_BYTE, FM_AREG, 8'h00, 4'h0, 4'h0, 1'b1);
        go(OP_CMP, SZ_WORD, FM_MEM, 8'h00, 4'h0, 4'h0, 1'b1);
        go(OP_AND, SZ_LONG, FM_DREG, 8'h0a, 4'h2, 4'h0, 1'b0);
        go(OP_OR, SZ_WORD, FM_MEM, 8'h0c, 4'h2, 4'h1, 1'b0);
        $display("standard and refusal test done");
    endtask
    task automatic t_muldiv();
        go(OP_SDIV, SZ_WORD, FM_DREG, 8'h7e, 4'h2, 4'h0, 1'b0);
        go(OP_UDIV, SZ_WORD, FM_DREG, 8'h70, 4'h2, 4'h0, 1'b0);
        go(OP_MUL, SZ_WORD, FM_DREG, 8'h2e, 4'h2, 4'h0, 1'b0);
        src_reg = 1'b1;
        go(OP_MUL, SZ_WORD, FM_DREG, 8'h28, 4'h1, 4'h0, 1'b0);
        src_reg = 1'b0;
        $display("multiply divide test done");
    endtask
    task automatic t_imm();
        go(OP_ADD_IMMEDIATE, SZ_LONG, FM_DREG, 8'h0e, 4'h3, 4'h0, 1'b0);
        go(OP_SUBTRACT_IMMEDIATE, SZ_WORD, FM_MEM, 8'h10, 4'h3, 4'h1, 1'b0);
        go(OP_COMPARE_IMMEDIATE, SZ_LONG, FM_MEM, 8'h10, 4'h4, 4'h0, 1'b0);
        go(OP_QADD, SZ_WORD, FM_AREG, 8'h04, 4'h1, 4'h0, 1'b0);
        go(OP_QMOVE, SZ_LONG, FM_DREG, 8'h04, 4'h1, 4'h0, 1'b0);
        go(OP_QSUB, SZ_LONG, FM_MEM, 8'h10, 4'h2, 4'h2, 1'b0);
        go(OP_ORI, SZ_LONG, FM_MEM, 8'h18, 4'h4, 4'h2, 1'b0);
        go(OP_XORI, SZ_WORD, FM_DREG, 8'h08, 4'h2, 4'h0, 1'b0);
        go(OP_AND_IMMEDIATE, SZ_BYTE, FM_AREG, 8'h00, 4'h0, 4'h0, 1'b1);
        $display("immediate test done");
    endtask
    task automatic t_single();
        go(OP_NEG, SZ_WORD, FM_DREG, 8'h04, 4'h1, 4'h0, 1'b0);
        go(OP_DNEG, SZ_BYTE, FM_DREG, 8'h06, 4'h1, 4'h0, 1'b0);
        go(OP_TSET, SZ_BYTE, FM_MEM, 8'h12, 4'h3, 4'h1, 1'b0);
        go(OP_NOT, SZ_LONG, FM_MEM, 8'h10, 4'h2, 4'h2, 1'b0);
        go(OP_NEGATE_WITH_EXTEND, SZ_LONG, FM_DREG, 8'h06, 4'h1, 4'h0, 1'b0);
        go(OP_SETCC, SZ_BYTE, FM_MEM, 8'h0c, 4'h2, 4'h1, 1'b0);
        go(OP_SETCC, SZ_WORD, FM_DREG, 8'h00, 4'h0, 4'h0, 1'b1);
        ea_writes = 4'h1;
        go(OP_TST, SZ_LONG, FM_MEM, 8'h08, 4'h2, 4'h1, 1'b0);
        ea_writes = 4'h0;
        $display("single operand test done");
    endtask
    task automatic t_loop();
        loop_mode = 1'b1;
        ea_indirect = 1'b1;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h10, 4'h1, 4'h0, 1'b0);
        go(OP_SUB, SZ_LONG, FM_DREG, 8'h14, 4'h2, 4'h0, 1'b0);
        go(OP_XOR, SZ_WORD, FM_DREG, 8'h00, 4'h0, 4'h0, 1'b1);
        loop_case = LP_TRUE;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h16, 4'h3, 4'h0, 1'b0);
        go(OP_ADD, SZ_LONG, FM_DREG, 8'h1c, 4'h4, 4'h0, 1'b0);
        loop_case = LP_EXP;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h14, 4'h3, 4'h0, 1'b0);
        go(OP_ADD, SZ_LONG, FM_MEM, 8'h1c, 4'h4, 4'h2, 1'b0);
        go(OP_CMP, SZ_LONG, FM_AREG, 8'h14, 4'h4, 4'h0, 1'b0);
        loop_case = LP_CONT;
        ea_predec = 1'b1;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h12, 4'h1, 4'h0, 1'b0);
        {ea_predec, ea_indirect} = 2'b00;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h00, 4'h0, 4'h0, 1'b1);
        loop_mode = 1'b0;
        $display("loop mode test done");
    endtask
    task automatic t_stall();
        slow = 1'b1;
        go(OP_NEG, SZ_WORD, FM_DREG, 8'h04, 4'h1, 4'h0, 1'b0);
        slow = 1'b0;
        op = OP_UDIV;
        start = 1'b1;
        @(posedge clk);
        #2 start = 1'b0;
        repeat (5) @(posedge clk);
        #2 cmp_f(busy, 1'b1);
        resetn = 1'b0;
        @(posedge clk);
        #2 cmp_f(busy, 1'b0);
        cmp_f(done, 1'b0);
        resetn = 1'b1;
        go(OP_ADD, SZ_WORD, FM_DREG, 8'h08, 4'h2, 4'h0, 1'b0);
        $display("stall and reset test done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {start, src_reg, loop_mode, ea_indirect, ea_predec, slow} = 6'h00;
        src_dreg = 1'b1;
        op = OP_ADD;
        size = SZ_WORD;
        form = FM_DREG;
        loop_case = LP_CONT;
        ea_clocks = 8'h04;
        ea_reads = 4'h1;
        ea_writes = 4'h0;
        repeat (8) @(posedge clk);
        #2 resetn = 1'b1;
        t_std();
        t_muldiv();
        t_imm();
        t_single();
        t_loop();
        t_stall();
        give_verdict();
    end
endmodule
